// >>> pkg/pwrseq_pkg.sv
`default_nettype none
package pwrseq_pkg;

	localparam int CLK_HZ         = 20_000_000;
	localparam int CYC_PER_MS     = CLK_HZ / 1000;
	localparam int TIMER_W        = 28;

	// times in their own units
	localparam int ON_DEBOUNCE_MS = 100;
	localparam int UART_ON_S      = 5;
	localparam int STATUS_ON_S    = 6;
	localparam int DETACH_MS      = 500;
	localparam int OFF_STATUS_S   = 2;
	localparam int LONG_HOLD_S    = 10;
	localparam int RESET_PULSE_MS = 10;

	// derived cycle counts (exact multiples, no rounding needed)
	localparam int ON_DEBOUNCE_CYC = ON_DEBOUNCE_MS * CYC_PER_MS;
	localparam int UART_ON_CYC     = UART_ON_S * CLK_HZ;
	localparam int STATUS_ON_CYC   = STATUS_ON_S * CLK_HZ;
	localparam int DETACH_CYC      = DETACH_MS * CYC_PER_MS;
	localparam int OFF_STATUS_CYC  = OFF_STATUS_S * CLK_HZ;
	localparam int LONG_HOLD_CYC   = LONG_HOLD_S * CLK_HZ;
	localparam int RESET_PULSE_CYC = RESET_PULSE_MS * CYC_PER_MS;

	// idle levels of the pins (pull-up on key, pull-down on boot)
	localparam logic KEY_IDLE  = 1'b1;
	localparam logic BOOT_IDLE = 1'b0;

	typedef enum logic [6:0] {
		st_off     = 7'h01,
		st_boot    = 7'h02,
		st_on      = 7'h04,
		st_saving  = 7'h08,
		st_detach  = 7'h10,
		st_save    = 7'h20,
		st_reset   = 7'h40
	} seq_state_e;

endpackage
`default_nettype wire

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int         WIDTH   = 2,
	parameter logic [1:0] RST_VAL = 2'h0
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	//////////////////////////////////////////////////////////////////////
	// two-flop synchroniser
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_comb begin
				meta_next[i] = clk_en ? pin_in[i] : meta_reg[i];
				sync_next[i] = clk_en ? meta_reg[i] : sync_reg[i];
			end
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					meta_reg[i] <= RST_VAL[i];
					sync_reg[i] <= RST_VAL[i];
				end else begin
					meta_reg[i] <= meta_next[i];
					sync_reg[i] <= sync_next[i];
				end
			end
		end
	endgenerate

	assign pin_out = sync_reg;

endmodule
`default_nettype wire

// >>> logic/key_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module key_hold_timer #(
	parameter int DEBOUNCE_CYC = 2_000_000,
	parameter int LONG_CYC     = 200_000_000
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic clk_en,
	input  wire logic key_low,
	output logic      press_valid,
	output logic      long_release
);
	import pwrseq_pkg::*;

	localparam logic [TIMER_W-1:0] DEB_LAST = TIMER_W'(DEBOUNCE_CYC - 1);
	localparam logic [TIMER_W-1:0] LONG_MAX = TIMER_W'(LONG_CYC);

	logic [TIMER_W-1:0] low_cnt_reg;
	logic [TIMER_W-1:0] low_cnt_next;
	logic               press_reg;
	logic               press_next;
	logic               long_reg;
	logic               long_next;

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		low_cnt_next = low_cnt_reg;
		// held while frozen so a pulse is not lost under a low enable
		press_next   = press_reg;
		long_next    = long_reg;
		if (clk_en) begin
			press_next = 1'b0;
			long_next  = 1'b0;
			if (key_low) begin
				if (low_cnt_reg == DEB_LAST)
					press_next = 1'b1;
				// saturate so a stuck key never wraps into a new press
				if (low_cnt_reg != LONG_MAX)
					low_cnt_next = low_cnt_reg + 1'b1;
			end else begin
				long_next    = (low_cnt_reg == LONG_MAX);
				low_cnt_next = '0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			low_cnt_reg <= '0;
			press_reg   <= 1'b0;
			long_reg    <= 1'b0;
		end else begin
			low_cnt_reg <= low_cnt_next;
			press_reg   <= press_next;
			long_reg    <= long_next;
		end
	end

	assign press_valid  = press_reg;
	assign long_release = long_reg;

endmodule
`default_nettype wire

// >>> logic/power_key_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module power_key_sequencer
	import pwrseq_pkg::*;
#(
	parameter int ON_DEBOUNCE_CYC = pwrseq_pkg::ON_DEBOUNCE_CYC,
	parameter int UART_ON_CYC     = pwrseq_pkg::UART_ON_CYC,
	parameter int STATUS_ON_CYC   = pwrseq_pkg::STATUS_ON_CYC,
	parameter int DETACH_CYC      = pwrseq_pkg::DETACH_CYC,
	parameter int OFF_STATUS_CYC  = pwrseq_pkg::OFF_STATUS_CYC,
	parameter int LONG_HOLD_CYC   = pwrseq_pkg::LONG_HOLD_CYC,
	parameter int RESET_PULSE_CYC = pwrseq_pkg::RESET_PULSE_CYC
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic clk_en,
	input  wire logic power_key,
	input  wire logic boot_request_in,
	input  wire logic power_off_command,
	input  wire logic power_saving_request,
	input  wire logic supply_over_voltage,
	input  wire logic supply_under_voltage,
	input  wire logic over_temperature,
	input  wire logic under_temperature,
	output logic      status,
	output logic      uart_enable,
	output logic      power_enable,
	output logic      network_detach_req,
	output logic      save_data_req,
	output logic      system_reset,
	output logic      power_saving_state
);
	import pwrseq_pkg::*;

	localparam logic [TIMER_W-1:0] UART_LAST   = TIMER_W'(UART_ON_CYC - 1);
	localparam logic [TIMER_W-1:0] STATUS_LAST = TIMER_W'(STATUS_ON_CYC - 1);
	localparam logic [TIMER_W-1:0] DETACH_LAST = TIMER_W'(DETACH_CYC - 1);
	localparam logic [TIMER_W-1:0] OFF_LAST    = TIMER_W'(OFF_STATUS_CYC - 1);
	localparam logic [TIMER_W-1:0] RESET_LAST  = TIMER_W'(RESET_PULSE_CYC - 1);

	function automatic logic is_up(input seq_state_e s);
		is_up = (s == st_on) || (s == st_saving) ||
			(s == st_detach) || (s == st_save);
	endfunction

	logic [1:0]         pins_sync;
	logic               key_low;
	logic               boot_sync;
	logic               press_valid;
	logic               long_release;
	logic               fault;

	seq_state_e         state_reg;
	seq_state_e         state_next;
	logic [TIMER_W-1:0] timer_reg;
	logic [TIMER_W-1:0] timer_next;
	logic               pending_on_reg;
	logic               pending_on_next;
	logic               boot_prev_reg;
	logic               boot_prev_next;
	logic               boot_rise;

	logic               status_reg;
	logic               status_next;
	logic               uart_reg;
	logic               uart_next;
	logic               power_reg;
	logic               power_next;
	logic               detach_reg;
	logic               detach_next;
	logic               save_reg;
	logic               save_next;
	logic               sys_reset_reg;
	logic               sys_reset_next;
	logic               saving_reg;
	logic               saving_next;

	//////////////////////////////////////////////////////////////////////
	// pins cross into the clock domain
	pin_sync #(
		.WIDTH   (2),
		.RST_VAL ({BOOT_IDLE, KEY_IDLE})
	) u_pin_sync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.clk_en  (clk_en),
		.pin_in  ({boot_request_in, power_key}),
		.pin_out (pins_sync)
	);

	// the single key feeds on, wake from saving and reset
	assign key_low   = ~pins_sync[0];
	assign boot_sync = pins_sync[1];
	assign boot_rise = boot_sync & ~boot_prev_reg;

	key_hold_timer #(
		.DEBOUNCE_CYC (ON_DEBOUNCE_CYC),
		.LONG_CYC     (LONG_HOLD_CYC)
	) u_key_hold_timer (
		.sys_clk      (sys_clk),
		.srst         (srst),
		.clk_en       (clk_en),
		.key_low      (key_low),
		.press_valid  (press_valid),
		.long_release (long_release)
	);

	assign fault = supply_over_voltage | supply_under_voltage |
		over_temperature | under_temperature;

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next      = state_reg;
		timer_next      = timer_reg;
		pending_on_next = pending_on_reg;
		boot_prev_next  = boot_prev_reg;
		if (clk_en) begin
			boot_prev_next = boot_sync;
			timer_next     = timer_reg + 1'b1;
			case (state_reg)
				st_off: begin
					// debounced press, boot edge or queued request
					if (press_valid || boot_rise || pending_on_reg) begin
						state_next      = st_boot;
						timer_next      = '0;
						pending_on_next = 1'b0;
					end
				end
				st_boot: begin
					if (fault) begin
						state_next = st_detach;
						timer_next = '0;
					// initialisation done at fixed point in window
					end else if (timer_reg == STATUS_LAST) begin
						state_next = st_on;
					end
				end
				st_on: begin
					// off request opens with network detach
					if (fault || power_off_command) begin
						state_next = st_detach;
						timer_next = '0;
					end else if (power_saving_request) begin
						state_next = st_saving;
					end
				end
				st_saving: begin
					if (fault) begin
						state_next = st_detach;
						timer_next = '0;
					// wake on raw synced key or boot level
					end else if (key_low || boot_sync) begin
						state_next = st_on;
					end
				end
				st_detach: begin
					if (timer_reg == DETACH_LAST)
						state_next = st_save;
				end
				st_save: begin
					// timer runs on from the request
					if (timer_reg == OFF_LAST)
						state_next = st_off;
				end
				st_reset: begin
					if (timer_reg == RESET_LAST) begin
						state_next = st_boot;
						timer_next = '0;
					end
				end
				default: begin
					state_next = st_off;
					timer_next = '0;
				end
			endcase
			// a press during shutdown is kept, not dropped
			if ((state_reg == st_detach || state_reg == st_save) &&
				(press_valid || boot_rise))
				pending_on_next = 1'b1;
			// long hold overrides any powered state
			if (long_release && state_reg != st_off) begin
				state_next      = st_reset;
				timer_next      = '0;
				pending_on_next = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg      <= st_off;
			timer_reg      <= '0;
			pending_on_reg <= 1'b0;
			boot_prev_reg  <= BOOT_IDLE;
		end else begin
			state_reg      <= state_next;
			timer_reg      <= timer_next;
			pending_on_reg <= pending_on_next;
			boot_prev_reg  <= boot_prev_next;
		end
	end

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		// shutdown keeps status only if boot had finished
		status_next    = (state_next == st_on) ||
			(state_next == st_saving) || (is_up(state_next) && status_reg);
		// serial port comes up inside the boot window
		uart_next      = status_next || (is_up(state_next) && uart_reg) ||
			(state_next == st_boot && timer_next >= UART_LAST);
		power_next     = (state_next != st_off);
		detach_next    = (state_next == st_detach);
		save_next      = (state_next == st_save);
		sys_reset_next = (state_next == st_reset);
		saving_next    = (state_next == st_saving);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status_reg    <= 1'b0;
			uart_reg      <= 1'b0;
			power_reg     <= 1'b0;
			detach_reg    <= 1'b0;
			save_reg      <= 1'b0;
			sys_reset_reg <= 1'b0;
			saving_reg    <= 1'b0;
		end else begin
			status_reg    <= status_next;
			uart_reg      <= uart_next;
			power_reg     <= power_next;
			detach_reg    <= detach_next;
			save_reg      <= save_next;
			sys_reset_reg <= sys_reset_next;
			saving_reg    <= saving_next;
		end
	end

	assign status             = status_reg;
	assign uart_enable        = uart_reg;
	assign power_enable       = power_reg;
	assign network_detach_req = detach_reg;
	assign save_data_req      = save_reg;
	assign system_reset       = sys_reset_reg;
	assign power_saving_state = saving_reg;

	//////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_press_in_off;
		clk_en && press_valid && state_reg == st_off;
	endsequence

	sequence s_enter_boot;
		state_reg == st_boot && timer_reg == '0 && power_enable;
	endsequence

	sequence s_off_request;
		clk_en && state_reg == st_on && power_off_command && !long_release;
	endsequence

	sequence s_detach_phase;
		state_reg == st_detach && network_detach_req && status;
	endsequence

	boot_on_press_a: assert property (
		s_press_in_off |=> s_enter_boot)
		else $error("debounced press did not start boot");

	status_only_up_a: assert property (
		status |-> is_up(state_reg) && power_enable)
		else $error("status high outside powered ready states");

	status_rise_a: assert property (
		$rose(status) |-> $past(state_reg) == st_boot &&
			$past(timer_reg) == STATUS_LAST)
		else $error("status rose at wrong time");

	uart_before_status_a: assert property (
		$rose(status) |-> $past(uart_enable))
		else $error("serial port not up when status rose");

	off_order_a: assert property (
		s_off_request |=> s_detach_phase ##1
			(state_reg == st_detach) [*1])
		else $error("power-off did not open with detach");

	power_drop_a: assert property (
		$fell(power_enable) && !$past(srst) |->
			$past(state_reg) == st_save && $past(save_data_req))
		else $error("power removed before data save");

	fault_down_a: assert property (
		clk_en && fault && state_reg == st_on && !long_release
			|=> state_reg == st_detach)
		else $error("fault did not start shutdown");

	status_fall_a: assert property (
		$fell(status) && !system_reset && !$past(srst) |->
			!uart_enable && $past(timer_reg) == OFF_LAST)
		else $error("status dropped off the 2 s mark");

	repower_a: assert property (
		clk_en && state_reg == st_off && pending_on_reg
			|=> state_reg == st_boot)
		else $error("queued power-on not accepted");

	saving_exit_a: assert property (
		clk_en && state_reg == st_saving && !fault && !long_release &&
			(key_low || boot_sync) |=> state_reg == st_on &&
			!power_saving_state)
		else $error("power-saving state did not exit");

	long_reset_a: assert property (
		clk_en && long_release && state_reg != st_off
			|=> system_reset && state_reg == st_reset)
		else $error("long hold release missed reset");

endmodule
`default_nettype wire

// >>> tb/key_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module key_host_model (
	input  wire logic sys_clk,
	output logic      power_key,
	output logic      boot_request_in
);

	////////////////////////////////////////////////////////////////////////
	initial begin
		power_key = 1'b1;
		boot_request_in = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// commanded hold length
	// short or long holds happen only when a bench scenario asks for them
	task automatic press(input int cycles);
		power_key = 1'b0;
		repeat (cycles) @(posedge sys_clk);
		#2;
		power_key = 1'b1;
	endtask

	// boot level drive
	// released means back to the pull-down level, never left floating
	task automatic set_boot(input logic level);
		boot_request_in = level;
	endtask

endmodule
`default_nettype wire

// >>> tb/power_key_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_key_sequencer_bench;

	typedef struct {
		int         act;
		int         arg;
		logic [6:0] mask;
		logic [6:0] val;
		int         lo;
		int         hi;
	} row_s;

	logic       sys_clk;
	logic       srst;
	logic       clk_en;
	logic       off_cmd;
	logic       save_req;
	logic [3:0] fault;
	logic       power_key;
	logic       boot_request_in;
	logic       status;
	logic       uart_enable;
	logic       power_enable;
	logic       detach;
	logic       save;
	logic       sys_reset;
	logic       saving;
	logic [6:0] outs;
	int         bad_count;
	int         samples_checked;
	int         cycles;

	assign outs = {status, uart_enable, power_enable, detach, save,
		sys_reset, saving};

	// act: 0 none, 1 key press, 2 off, 3 boot level, 4 saving, 6 idle
	row_s rows [14] = '{
		'{1, 20, 7'h10, 7'h10, 9, 14},
		'{0, 0, 7'h20, 7'h20, 38, 42},
		'{0, 0, 7'h40, 7'h40, 8, 12},
		'{2, 0, 7'h08, 7'h08, 0, 2},
		'{0, 0, 7'h0c, 7'h04, 8, 11},
		'{0, 0, 7'h74, 7'h00, 18, 22},
		'{3, 1, 7'h10, 7'h10, 1, 5},
		'{3, 0, 7'h40, 7'h40, 45, 52},
		'{4, 0, 7'h41, 7'h41, 0, 2},
		'{1, 20, 7'h01, 7'h00, 1, 13},
		'{6, 25, 7'h41, 7'h40, 0, 2},
		'{4, 0, 7'h01, 7'h01, 0, 2},
		'{3, 1, 7'h01, 7'h00, 1, 5},
		'{3, 0, 7'h41, 7'h40, 0, 2}
	};

	////////////////////////////////////////////////////////////////////////
	// short counts keep the run to about a thousand cycles
	localparam int DEB_CYC    = 8;
	localparam int UART_CYC   = 40;
	localparam int STATUS_CYC = 50;
	localparam int DETACH_LEN = 10;
	localparam int OFF_CYC    = 30;
	localparam int LONG_CYC   = 100;
	localparam int RST_CYC    = 5;

	power_key_sequencer #(
		.ON_DEBOUNCE_CYC (DEB_CYC),
		.UART_ON_CYC     (UART_CYC),
		.STATUS_ON_CYC   (STATUS_CYC),
		.DETACH_CYC      (DETACH_LEN),
		.OFF_STATUS_CYC  (OFF_CYC),
		.LONG_HOLD_CYC   (LONG_CYC),
		.RESET_PULSE_CYC (RST_CYC)
	) dut_u (
		.sys_clk              (sys_clk),
		.srst                 (srst),
		.clk_en               (clk_en),
		.power_key            (power_key),
		.boot_request_in      (boot_request_in),
		.power_off_command    (off_cmd),
		.power_saving_request (save_req),
		.supply_over_voltage  (fault[0]),
		.supply_under_voltage (fault[1]),
		.over_temperature     (fault[2]),
		.under_temperature    (fault[3]),
		.status               (status),
		.uart_enable          (uart_enable),
		.power_enable         (power_enable),
		.network_detach_req   (detach),
		.save_data_req        (save),
		.system_reset         (sys_reset),
		.power_saving_state   (saving)
	);

	key_host_model part_u (
		.sys_clk         (sys_clk),
		.power_key       (power_key),
		.boot_request_in (boot_request_in)
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial cycles = 0;
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 4000) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// windows allow a cycle either way for the pin synchronisers
	task automatic wait_outs(input logic [6:0] mask, input logic [6:0] val,
		input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (((outs & mask) !== val) && n < hi);
		samples_checked++;
		if (((outs & mask) !== val) || n < lo) begin
			bad_count++;
			$display("mismatch outs expected %h seen %h mask %h after %0d",
				val, outs & mask, mask, n);
		end
		#1;
	endtask

	task automatic hold_outs(input logic [6:0] mask, input logic [6:0] val,
		input int cyc);
		repeat (cyc) begin
			@(posedge sys_clk);
			#1;
			samples_checked++;
			if ((outs & mask) !== val) begin
				bad_count++;
				$display("mismatch outs expected %h seen %h", val, outs & mask);
			end
		end
		#1;
	endtask

	// every action starts two nanoseconds after an edge
	task automatic do_act(input int act, input int arg);
		case (act)
			1: fork
				part_u.press(arg);
			join_none
			2: off_cmd = 1'b1;
			3: part_u.set_boot(arg[0]);
			4: save_req = 1'b1;
			5: fault[arg[1:0]] = 1'b1;
			6: repeat (arg) @(posedge sys_clk);
			default: ;
		endcase
		if (act != 0) begin
			@(posedge sys_clk);
			#2;
			off_cmd = 1'b0;
			save_req = 1'b0;
			fault = 4'h0;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		clk_en = 1'b1;
		off_cmd = 1'b0;
		save_req = 1'b0;
		fault = 4'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (11) @(posedge sys_clk);
		wait_outs(7'h7f, 7'h00, 0, 1);
		srst = 1'b0;
		@(posedge sys_clk);
		#2;
		foreach (rows[i]) begin
			do_act(rows[i].act, rows[i].arg);
			wait_outs(rows[i].mask, rows[i].val, rows[i].lo, rows[i].hi);
		end
		for (int f = 0; f < 4; f++) begin
			do_act(5, f);
			wait_outs(7'h08, 7'h08, 0, 2);
			wait_outs(7'h10, 7'h00, 26, 31);
			do_act(3, 1);
			wait_outs(7'h10, 7'h10, 1, 5);
			do_act(3, 0);
			wait_outs(7'h40, 7'h40, 45, 52);
		end
		// press made during shutdown is held over until power is off
		do_act(2, 0);
		do_act(1, 20);
		wait_outs(7'h10, 7'h00, 26, 31);
		wait_outs(7'h10, 7'h10, 0, 3);
		wait_outs(7'h40, 7'h40, 45, 52);
		do_act(2, 0);
		wait_outs(7'h10, 7'h00, 27, 31);
		do_act(1, 5);
		hold_outs(7'h7f, 7'h00, 40);
		do_act(3, 1);
		wait_outs(7'h10, 7'h10, 1, 5);
		do_act(3, 0);
		// a low enable freezes the boot timer, so status comes late
		clk_en = 1'b0;
		hold_outs(7'h7f, 7'h10, 20);
		clk_en = 1'b1;
		wait_outs(7'h40, 7'h40, 45, 52);
		do_act(1, 110);
		wait_outs(7'h12, 7'h12, 105, 116);
		wait_outs(7'h12, 7'h10, 3, 7);
		srst = 1'b1;
		wait_outs(7'h7f, 7'h00, 0, 1);
		srst = 1'b0;
		hold_outs(7'h7f, 7'h00, 5);
		// a fault during boot shuts down without ever showing status
		do_act(3, 1);
		wait_outs(7'h10, 7'h10, 1, 5);
		do_act(3, 0);
		do_act(5, 0);
		hold_outs(7'h40, 7'h00, 30);
		wait_outs(7'h10, 7'h00, 0, 2);
		print_verdict();
	end

endmodule
`default_nettype wire
